// file: urbs_top.sv
// receive buffer, status flags and registers of a serial port, on ahb-lite
// assumes a front end that reports start bits and finished frames
// the front end pulses frame_done at the first stop bit, with data,
// parity and first stop value valid in that same cycle
// start_detect is one cycle per accepted start bit
// read data is registered, so a read is answered in its data phase
// with no wait state; hreadyout never drops and hresp is always okay
// a data read pops the buffer at the edge that takes the address phase
// clearing receiver_enable flushes on the next edge, so a frame that
// arrives in the same cycle as the disabling write is lost as well
// unmapped or unaligned addresses read zero and drop writes
//
// Behaviour
// - data read advances buffer, flags follow
// - complete flag high while buffer holds frames
// - receiver disable flushes buffer at once
// - irq requested while enabled and complete
// - error flags stored with their frame
// - status writes leave error flags alone
// - error flags never raise an interrupt
// - frame error mirrors first stop bit
// - only first stop bit is checked
// - overrun when full, waiting, new start
// - overrun clears on successful transfer
// - parity error zero when checking off
// - upper bit enables, lower selects parity
// - checker compares parity, stores result
// - parity error only if enabled then
// - disable is immediate, abandons frame, frees pin
// - transfer on first stop, ignore second
// - unused upper data bits read zero
// - enable gives pin to receiver
`timescale 1ns/1ps
`default_nettype none
module urbs_top
   import urbs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // receiver front end
   input wire logic start_detect,
   input wire logic frame_done,
   input wire logic [8:0] shift_data,
   input wire logic shift_parity,
   input wire logic shift_stop1,
   output logic rx_pin_override,
   output logic rx_abort,
   output logic [2:0] rx_char_size,
   output logic rx_two_stop,
   // interrupt request
   input wire logic global_irq_enable,
   output logic rx_complete_irq
);
   // register state
   logic [7:0] control_reg; // serial_control_reg
   logic [7:0] format_reg; // frame_format_reg
   // frame waiting in the shift register
   logic pend_valid_reg;
   logic [URBS_ENTRY_W-1:0] pend_entry_reg;
   logic overrun_reg; // data lost since last transfer
   // bus data phase
   logic wr_pend_reg;
   logic [3:0] wr_addr_reg;
   logic [31:0] hrdata_reg;
   // buffer
   logic [URBS_ENTRY_W-1:0] head;
   logic [1:0] count;
   logic push;
   logic pop;
   logic flush;
   // checker outputs
   logic [8:0] chk_data;
   logic chk_fe;
   logic chk_upe;
   // decoded bus
   logic addr_ok;
   logic rd_take;
   logic wr_take;
   logic [3:0] off;
   // named flags
   logic receiver_enable;
   logic receive_complete_flag;
   logic [7:0] status_val;
   logic [7:0] control_val;

   assign receiver_enable = control_reg[URBS_CT_RXEN];
   assign receive_complete_flag = (count != 2'h0);
   assign flush = ~receiver_enable;

   // pin ownership and front-end abort follow enable
   assign rx_pin_override = receiver_enable;
   assign rx_abort = ~receiver_enable;
   assign rx_char_size = format_reg[URBS_FM_CS_LO +: 3];
   assign rx_two_stop = format_reg[URBS_FM_STOP];

   // interrupt from complete flag only, never from errors
   assign rx_complete_irq = control_reg[URBS_CT_RXCIE] & receive_complete_flag
                            & global_irq_enable;

   // ---------------------------------------------------------------
   // frame checker
   urbs_check u_check (
      .clk(clk),
      .rst_n(rst_n),
      .raw_data(shift_data),
      .parity_bit(shift_parity),
      .first_stop(shift_stop1),
      .char_size(format_reg[URBS_FM_CS_LO +: 3]),
      .parity_en(format_reg[URBS_FM_PEN]),
      .parity_odd(format_reg[URBS_FM_PODD]),
      .data(chk_data),
      .frame_err(chk_fe),
      .parity_err(chk_upe)
   );

   // ---------------------------------------------------------------
   // ahb decode: zero-wait slave, always okay
   assign off = haddr[3:0];
   assign addr_ok = (haddr[31:4] == 28'h0) && (haddr[1:0] == 2'h0);
   assign rd_take = hsel && hready && (htrans == URBS_HTRANS_NONSEQ) && !hwrite;
   assign wr_take = hsel && hready && (htrans == URBS_HTRANS_NONSEQ) && hwrite;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;

   // status and control as software sees them
   always_comb begin
      status_val = 8'h00;
      status_val[URBS_ST_RXC] = receive_complete_flag;
      status_val[URBS_ST_FE] = head[URBS_E_FE];
      status_val[URBS_ST_DOR] = head[URBS_E_DOR];
      status_val[URBS_ST_UPE] = head[URBS_E_UPE];
      control_val = control_reg;
      control_val[URBS_CT_RX9] = head[8];
   end

   // data read pops only a non-empty buffer
   assign pop = rd_take && addr_ok && (off == URBS_DATA_OFF)
                && receive_complete_flag && receiver_enable;

   // read data captured in the address phase, shown in the data phase
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (rd_take) begin
         if (!addr_ok) begin
            hrdata_reg <= 32'h0000_0000; // unmapped reads zero
         end else begin
            unique case (off)
               URBS_STATUS_OFF: hrdata_reg <= {24'h0, status_val};
               URBS_CONTROL_OFF: hrdata_reg <= {24'h0, control_val};
               URBS_FORMAT_OFF: hrdata_reg <= {24'h0, format_reg};
               URBS_DATA_OFF: hrdata_reg <= {24'h0, head[7:0]};
               default: hrdata_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   // write address held over to the data phase
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 4'h0;
      end else if (hready) begin
         wr_pend_reg <= wr_take && addr_ok;
         wr_addr_reg <= off;
      end
   end

   // control and format registers; status writes are dropped
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         control_reg <= URBS_CONTROL_RST;
         format_reg <= URBS_FORMAT_RST;
      end else if (wr_pend_reg) begin
         unique case (wr_addr_reg)
            URBS_CONTROL_OFF: begin
               control_reg <= hwdata[7:0] & 8'h90; // ninth bit read only
            end
            URBS_FORMAT_OFF: begin
               format_reg <= hwdata[7:0] & 8'h3f;
            end
            default: begin
               control_reg <= control_reg; // status write
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // shift-register holding stage and overrun tracking
   assign push = pend_valid_reg && (count != 2'h2) && receiver_enable;

   always_ff @(posedge clk) begin
      if (!rst_n || !receiver_enable) begin
         pend_valid_reg <= 1'b0;
         pend_entry_reg <= '0;
      end else if (frame_done) begin
         // frame complete at first stop; second stop never looked at
         pend_valid_reg <= 1'b1;
         pend_entry_reg <= {chk_fe, 1'b0, chk_upe, chk_data};
      end else if (push) begin
         pend_valid_reg <= 1'b0;
      end
   end

   // overrun latched on a start while full and waiting; cleared by a transfer
   always_ff @(posedge clk) begin
      if (!rst_n || !receiver_enable) begin
         overrun_reg <= 1'b0;
      end else if (start_detect && pend_valid_reg && (count == 2'h2) && !pop) begin
         overrun_reg <= 1'b1;
      end else if (push) begin
         overrun_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // two-entry buffer
   urbs_fifo u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .flush(flush),
      .push(push),
      .push_data({pend_entry_reg[URBS_E_FE], overrun_reg,
                  pend_entry_reg[URBS_E_UPE:0]}),
      .pop(pop),
      .head(head),
      .count(count)
   );

   // ---------------------------------------------------------------
   // checks
   // complete flag tracks the fill level
   rxc_level_a: assert property (@(posedge clk) disable iff (!rst_n)
      status_val[URBS_ST_RXC] == (count != 2'h0)) else $error("complete flag wrong");

   // buffer is empty one edge after the receiver goes off
   flush_empty_a: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(receiver_enable) |=> !receive_complete_flag) else $error("flush failed");

   // disabled receiver keeps buffer, holding stage and overrun clear
   flush_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      !receiver_enable |=> (count == 2'h0) && !pend_valid_reg && !overrun_reg)
      else $error("disabled receiver kept data");

   // request level follows enable, flag and global enable
   irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
      rx_complete_irq == (control_reg[URBS_CT_RXCIE] && receive_complete_flag
                          && global_irq_enable)) else $error("irq level wrong");

   // no request without a frame, whatever the error flags say
   irq_no_err_a: assert property (@(posedge clk) disable iff (!rst_n)
      !receive_complete_flag |-> !rx_complete_irq) else $error("irq without data");

   // a data read removes exactly one frame
   pop_step_a: assert property (@(posedge clk) disable iff (!rst_n)
      (pop && !push && receiver_enable) |=> (count == $past(count) - 2'h1))
      else $error("read did not advance buffer");

   // a transfer adds exactly one frame
   push_step_a: assert property (@(posedge clk) disable iff (!rst_n)
      (push && !pop) |=> (count == $past(count) + 2'h1))
      else $error("transfer did not fill buffer");

   // a full buffer takes no transfer
   full_no_push_a: assert property (@(posedge clk) disable iff (!rst_n)
      (count == 2'h2) |-> !push) else $error("transfer into full buffer");

   // waiting frame kept while the buffer stays full
   pend_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
      (pend_valid_reg && (count == 2'h2) && !pop && receiver_enable) |=> pend_valid_reg)
      else $error("waiting frame lost");

   // empty read leaves the buffer alone
   empty_read_a: assert property (@(posedge clk) disable iff (!rst_n)
      (rd_take && off == URBS_DATA_OFF && count == 2'h0 && !push && receiver_enable)
      |=> (count == 2'h0)) else $error("empty read changed buffer");

   // status writes touch no register
   status_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_pend_reg && wr_addr_reg == URBS_STATUS_OFF)
      |=> $stable(control_reg) && $stable(format_reg)) else $error("status write leaked");

   // overrun gone after a transfer
   dor_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
      (push && !start_detect) |=> !overrun_reg) else $error("overrun not cleared");

   // overrun raised on a start while full and waiting
   dor_set_a: assert property (@(posedge clk) disable iff (!rst_n)
      (start_detect && pend_valid_reg && count == 2'h2 && !pop && receiver_enable)
      |=> overrun_reg) else $error("overrun missed");

   // frame error taken from the first stop bit only
   fe_store_a: assert property (@(posedge clk) disable iff (!rst_n)
      (frame_done && receiver_enable)
      |=> (pend_entry_reg[URBS_E_FE] == !$past(shift_stop1)))
      else $error("frame error not stored");

   // no parity error stored while checking is off
   upe_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      (frame_done && receiver_enable && !format_reg[URBS_FM_PEN])
      |=> !pend_entry_reg[URBS_E_UPE]) else $error("parity error while off");

   // unused upper data bits cleared before storing
   data_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
      (frame_done && receiver_enable)
      |=> ((pend_entry_reg[8:0] & ~urbs_char_mask($past(rx_char_size))) == 9'h000))
      else $error("unused data bits set");

   // upper read data bits always zero
   hrdata_high_a: assert property (@(posedge clk) disable iff (!rst_n)
      hrdata[31:8] == 24'h00_0000) else $error("read data upper bits set");

   // ninth bit position of control never stored
   rx9_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
      !control_reg[URBS_CT_RX9]) else $error("ninth bit written");

   // pin belongs to the receiver while enabled
   pin_own_a: assert property (@(posedge clk) disable iff (!rst_n)
      rx_pin_override == control_reg[URBS_CT_RXEN]) else $error("pin ownership wrong");

   // front end aborted exactly while the pin is released
   abort_level_a: assert property (@(posedge clk) disable iff (!rst_n)
      rx_abort != rx_pin_override) else $error("abort level wrong");
endmodule // urbs_top
`default_nettype wire

// file: urbs_pkg.sv
// receive buffer and status block: shared offsets, field positions, resets
// assumes a 32-bit bus with word-aligned registers
package urbs_pkg;
   // register byte addresses
   localparam logic [3:0] URBS_STATUS_OFF = 4'h0; // serial_status_reg
   localparam logic [3:0] URBS_CONTROL_OFF = 4'h4; // serial_control_reg
   localparam logic [3:0] URBS_FORMAT_OFF = 4'h8; // frame_format_reg
   localparam logic [3:0] URBS_DATA_OFF = 4'hc; // serial_data_location
   // status field positions
   localparam int URBS_ST_RXC = 7; // receive_complete_flag
   localparam int URBS_ST_FE = 4; // frame_error_flag
   localparam int URBS_ST_DOR = 3; // overrun_flag
   localparam int URBS_ST_UPE = 2; // parity_error_flag
   // control field positions
   localparam int URBS_CT_RXCIE = 7; // receive_complete_irq_enable
   localparam int URBS_CT_RXEN = 4; // receiver_enable
   localparam int URBS_CT_RX9 = 1; // rx_ninth_bit, read only
   // format field positions
   localparam int URBS_FM_PEN = 5; // parity_enable_bit
   localparam int URBS_FM_PODD = 4; // parity_odd_even_bit
   localparam int URBS_FM_STOP = 3; // stop_bit_count_select
   localparam int URBS_FM_CS_LO = 0; // char_size_select, three bits
   // reset values
   localparam logic [7:0] URBS_CONTROL_RST = 8'h00;
   localparam logic [7:0] URBS_FORMAT_RST = 8'h03; // eight-bit characters
   // char_size_select codes
   localparam logic [2:0] URBS_CS_NINE = 3'h7;
   // buffer entry layout: {fe, dor, upe, data[8:0]}
   localparam int URBS_ENTRY_W = 12;
   localparam int URBS_E_FE = 11;
   localparam int URBS_E_DOR = 10;
   localparam int URBS_E_UPE = 9;
   localparam int URBS_DEPTH = 2;
   // ahb transfer type
   localparam logic [1:0] URBS_HTRANS_NONSEQ = 2'h2;

   // mask of valid data bits for a character size code
   function automatic logic [8:0] urbs_char_mask(input logic [2:0] cs);
      unique case (cs)
         3'h0: urbs_char_mask = 9'h01f;
         3'h1: urbs_char_mask = 9'h03f;
         3'h2: urbs_char_mask = 9'h07f;
         3'h7: urbs_char_mask = 9'h1ff;
         default: urbs_char_mask = 9'h0ff;
      endcase
   endfunction
endpackage

// file: urbs_fifo.sv
// two-entry receive buffer holding each frame with its error flags
// assumes push is only asserted while not full and pop only while not empty
`timescale 1ns/1ps
`default_nettype none
module urbs_fifo
   import urbs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic push,
   input wire logic [URBS_ENTRY_W-1:0] push_data,
   input wire logic pop,
   output logic [URBS_ENTRY_W-1:0] head,
   output logic [1:0] count
);
   logic [URBS_ENTRY_W-1:0] mem [URBS_DEPTH]; // entries
   logic rd_ptr_reg; // read slot
   logic wr_ptr_reg; // write slot
   logic [1:0] count_reg; // entries held

   // storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= push_data;
      end
   end

   // pointers and fill level; flush wins over everything
   always_ff @(posedge clk) begin
      if (!rst_n || flush) begin
         rd_ptr_reg <= 1'b0;
         wr_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (push) wr_ptr_reg <= ~wr_ptr_reg;
         if (pop) rd_ptr_reg <= ~rd_ptr_reg;
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   assign head = (count_reg == 2'h0) ? '0 : mem[rd_ptr_reg];
   assign count = count_reg;

   // level never exceeds two entries
   fifo_depth_a: assert property (@(posedge clk) disable iff (!rst_n)
      count_reg <= 2'h2) else $error("receive buffer over depth");
endmodule // urbs_fifo
`default_nettype wire

// file: urbs_check.sv
// frame checker: masks data, derives frame and parity error of one frame
// assumes its inputs describe a whole frame from the shift register
`timescale 1ns/1ps
`default_nettype none
module urbs_check
   import urbs_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [8:0] raw_data,
   input wire logic parity_bit,
   input wire logic first_stop,
   input wire logic [2:0] char_size,
   input wire logic parity_en,
   input wire logic parity_odd,
   output logic [8:0] data,
   output logic frame_err,
   output logic parity_err
);
   logic calc; // xor of received data bits

   always_comb begin
      data = raw_data & urbs_char_mask(char_size);
      calc = ^data;
      // even: bit equals data xor; odd: bit is its inverse
      parity_err = parity_en & (calc ^ parity_bit ^ parity_odd);
      frame_err = ~first_stop;
   end

   // parity error impossible while checking is off
   par_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      !parity_en |-> !parity_err) else $error("parity error while disabled");
endmodule // urbs_check
`default_nettype wire

// file: urbs_tx_model.sv
// remote transmitter as seen through the receiver front end
// assumes one frame request at a time, each go pulse held one cycle
`timescale 1ns/1ps
`default_nettype none
module urbs_tx_model #(
   parameter int GAP = 4 // one less than the cycles from start bit to first stop
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic go,
   input wire logic abort,
   input wire logic [8:0] d,
   input wire logic p,
   input wire logic s,
   output logic start_detect,
   output logic frame_done,
   output logic [8:0] shift_data,
   output logic shift_parity,
   output logic shift_stop1,
   output logic busy
);
   logic [3:0] cnt; // bit time left in the frame
   // one frame: start pulse, then payload at the first stop only
   always_ff @(posedge clk) begin
      start_detect <= 1'b0;
      frame_done <= 1'b0;
      // lines not qualified by frame_done keep changing
      shift_data <= ~shift_data;
      shift_parity <= ~shift_parity;
      shift_stop1 <= ~shift_stop1;
      if (!rst_n) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         shift_data <= 9'h000;
         shift_parity <= 1'b0;
         shift_stop1 <= 1'b0;
      end else if (abort) begin
         busy <= 1'b0; // frame in flight is dropped
      end else if (go && !busy) begin
         busy <= 1'b1;
         cnt <= GAP[3:0];
         start_detect <= 1'b1;
      end else if (busy && cnt == 4'h0) begin
         // handed over at the first stop, second stop never shown
         busy <= 1'b0;
         frame_done <= 1'b1;
         shift_data <= d;
         shift_parity <= p;
         shift_stop1 <= s;
      end else if (busy) begin
         cnt <= cnt - 4'h1;
      end
   end
endmodule // urbs_tx_model
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the receive buffer and status block
// assumes urbs_pkg and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import urbs_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, gie = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   wire logic hready, hresp, sd, fd, sp, ss, abort, ovr, two, irq, busy;
   wire logic [31:0] hrdata;
   wire logic [8:0] sdat;
   wire logic [2:0] csz;
   logic go = 1'b0, tp = 1'b0, tst = 1'b0;
   logic [8:0] td = 9'h0, f [4];
   logic [2:0] cs = 3'h3;
   logic pen = 1'b0, podd = 1'b0;
   int bad_count = 0, samples_checked = 0;
   always #50 clk = ~clk; // 10 MHz
   urbs_top DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hrdata(hrdata), .hresp(hresp), .start_detect(sd), .frame_done(fd), .shift_data(sdat),
      .shift_parity(sp), .shift_stop1(ss), .rx_pin_override(ovr), .rx_abort(abort),
      .rx_char_size(csz), .rx_two_stop(two), .global_irq_enable(gie), .rx_complete_irq(irq));
   urbs_tx_model PEER (.clk(clk), .rst_n(rst_n), .go(go), .abort(abort), .d(td), .p(tp),
      .s(tst), .start_detect(sd), .frame_done(fd), .shift_data(sdat), .shift_parity(sp),
      .shift_stop1(ss), .busy(busy));
   // verdict and end of run
   task automatic test_done;
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // one single ahb-lite transfer, zero or more wait states
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
         output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      htrans <= URBS_HTRANS_NONSEQ;
      // address phase held until ready; only the watchdog ends a hang
      do begin @(posedge clk); end while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do begin @(posedge clk); end while (hready !== 1'b1);
      r = hrdata;
   endtask
   function automatic logic [8:0] cmask(input logic [2:0] c);
      case (c)
         3'h0: return 9'h01f;
         3'h1: return 9'h03f;
         3'h2: return 9'h07f;
         3'h7: return 9'h1ff;
         default: return 9'h0ff;
      endcase
   endfunction
   task automatic set_fmt(input logic [2:0] c, input logic pe, input logic po, input logic st);
      cs = c;
      pen = pe;
      podd = po;
      bus(1, URBS_FORMAT_OFF, {26'h0, pe, po, st, c}, rd);
      @(negedge clk);
      chk("size", csz, c);
      chk("stops", two, st);
   endtask
   // one frame through the peer, then time to land in the buffer
   task automatic snd(input logic [8:0] d, input logic p, input logic s);
      int n;
      @(posedge clk);
      td <= d;
      tp <= p;
      tst <= s;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      n = 0;
      while (busy === 1'b1 && n < 40) begin @(posedge clk); n++; end
      if (n == 40) begin
         bad_count++; // peer hung: counts as a mismatch
      end
      repeat (2) @(posedge clk);
   endtask
   // status, then ninth bit, then data, as software must
   task automatic chk_frame(input logic [8:0] d, input logic p, input logic s, input logic dor);
      logic [31:0] st, ct, dt;
      logic [8:0] m;
      logic upe;
      m = d & cmask(cs);
      upe = pen & (^m ^ p ^ podd);
      bus(0, URBS_STATUS_OFF, 0, st);
      bus(0, URBS_CONTROL_OFF, 0, ct);
      bus(0, URBS_DATA_OFF, 0, dt);
      chk("rxc", st[URBS_ST_RXC], 1);
      chk("fe", st[URBS_ST_FE], !s);
      chk("dor", st[URBS_ST_DOR], dor);
      chk("upe", st[URBS_ST_UPE], upe);
      chk("rx9", ct[URBS_CT_RX9], m[8]);
      chk("data", dt, {24'h0, m[7:0]});
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      test_done;
   end
   initial begin
      int n;
      void'($urandom(61));
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      bus(0, URBS_STATUS_OFF, 0, rd);
      chk("st0", rd, 0);
      bus(0, URBS_CONTROL_OFF, 0, rd);
      chk("ct0", rd, URBS_CONTROL_RST);
      bus(0, URBS_FORMAT_OFF, 0, rd);
      chk("fm0", rd, URBS_FORMAT_RST);
      bus(0, 32'h10, 0, rd);
      chk("unmapped", rd, 0);
      chk("off", {abort, ovr}, 2'b10);
      bus(1, URBS_CONTROL_OFF, 32'h10, rd);
      @(negedge clk);
      chk("on", {abort, ovr}, 2'b01);
      bus(0, URBS_DATA_OFF, 0, rd);
      chk("empty_data", rd, 0);
      bus(0, URBS_STATUS_OFF, 0, rd);
      chk("empty", rd[URBS_ST_RXC], 0);
      // every size code and every parity mode, random payloads and stop setting
      for (int i = 0; i < 20; i++) begin
         f[0] = 9'($urandom);
         set_fmt(3'(i % 8), i[3] | i[4], i[2], 1'($urandom));
         snd(f[0], 1'($urandom), 1'($urandom));
         chk_frame(f[0], tp, tst, 0);
      end
      // fill, hold a third, lose it to a fourth: overrun
      set_fmt(3'h3, 1, 0, 0);
      for (int i = 0; i < 4; i++) f[i] = 9'($urandom);
      snd(f[0], ~^f[0][7:0], 0);
      for (int i = 1; i < 4; i++) snd(f[i], 0, 1);
      bus(1, URBS_STATUS_OFF, 32'h00, rd); // flag positions written as zero
      bus(1, URBS_FORMAT_OFF, 32'h03, rd); // parity off after receipt
      chk_frame(f[0], ~^f[0][7:0], 0, 0);
      chk_frame(f[1], 0, 1, 0);
      chk_frame(f[3], 0, 1, 1);
      set_fmt(3'h3, 1, 0, 0);
      snd(f[2], 0, 1);
      chk_frame(f[2], 0, 1, 0);
      // drain by reading data until the complete flag drops
      snd(f[0], 0, 1);
      snd(f[1], 0, 1);
      n = 0;
      bus(0, URBS_STATUS_OFF, 0, rd);
      while (rd[URBS_ST_RXC] === 1'b1 && n < 4) begin
         bus(0, URBS_DATA_OFF, 0, rd);
         n++;
         bus(0, URBS_STATUS_OFF, 0, rd);
      end
      chk("drain", n, 2);
      // disable flushes stored frames
      snd(f[0], 0, 1);
      snd(f[1], 0, 1);
      bus(1, URBS_CONTROL_OFF, 32'h00, rd);
      bus(0, URBS_STATUS_OFF, 0, rd);
      chk("flush", rd[URBS_ST_RXC], 0);
      chk("off2", {abort, ovr}, 2'b10);
      bus(1, URBS_CONTROL_OFF, 32'h10, rd);
      bus(0, URBS_STATUS_OFF, 0, rd);
      chk("stayempty", rd[URBS_ST_RXC], 0);
      // interrupt follows flag and global enable, with its enable set
      gie <= 1'b1;
      bus(1, URBS_CONTROL_OFF, 32'h90, rd);
      @(negedge clk);
      chk("irq_empty", irq, 0);
      snd(f[0], 1, 0);
      @(negedge clk);
      chk("irq_on", irq, 1);
      @(posedge clk);
      gie <= 1'b0;
      @(negedge clk);
      chk("irq_gie", irq, 0);
      @(posedge clk);
      gie <= 1'b1;
      bus(0, URBS_DATA_OFF, 0, rd); // handler read clears the flag
      chk("irq_data", rd, {24'h0, f[0][7:0]});
      @(negedge clk);
      chk("irq_read", irq, 0);
      test_done;
   end
endmodule // tb_top
`default_nettype wire
